/* File: src/rdl_consts.vh */
`ifndef RDL_CONSTS_VH
`define RDL_CONSTS_VH

// register offsets
`define RDL_ADDR_CONFIG   8'h24
`define RDL_ADDR_INTCTL   8'h25
`define RDL_ADDR_STATUS   8'h26
`define RDL_ADDR_DATA     8'h27

// configuration register fields
`define RDL_CFG_EN_BIT    0
`define RDL_CFG_ALT_BIT   1
`define RDL_CFG_RESET     2'h0

// interrupt control register fields
`define RDL_THR_MSB       2
`define RDL_THR_LSB       0
`define RDL_THR_RESET     3'h1
`define RDL_CNT_MSB       6
`define RDL_CNT_LSB       4

// status register fields
`define RDL_ST_FE_BIT     0
`define RDL_ST_OVR_BIT    1
`define RDL_ST_EOM_BIT    2
`define RDL_ST_FLG_BIT    3
`define RDL_ST_NVB_MSB    6
`define RDL_ST_NVB_LSB    4

// fifo entry layout
`define RDL_ENTRY_W       13
`define RDL_E_DATA_MSB    7
`define RDL_E_FLG         8
`define RDL_E_EOM         9
`define RDL_E_NVB_MSB     12
`define RDL_E_NVB_LSB     10

// link patterns
`define RDL_FLAG_PATTERN  8'h7e
`define RDL_STUFF_RUN     3'h5
`define RDL_ABORT_RUN     3'h6
`define RDL_IDLE_RUN      3'h7

`endif

/* File: src/rdl_fifo_mem.v */
`timescale 1ns/1ps
`include "rdl_consts.vh"

module rdl_fifo_mem #(
    parameter W  = `RDL_ENTRY_W,
    parameter AW = 2
) (
    input  wire          clk,
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [W-1:0]  wdata,
    input  wire [AW-1:0] raddr,
    output reg  [W-1:0]  rdata
);
    reg [W-1:0] mem [0:(1<<AW)-1];

    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // head word: bypass so a word written to the head slot shows at once
    always @(posedge clk) begin
        if (we && (waddr == raddr)) begin
            rdata <= wdata;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule

/* File: src/rdl_deframer.v */
`timescale 1ns/1ps
`include "rdl_consts.vh"

module rdl_deframer (
    input  wire       clk,
    input  wire       rst,
    input  wire       clear,
    input  wire       bitEn,
    input  wire       bitIn,
    output reg        dataValid,
    output reg        dataBit,
    output reg        flagHit,
    output reg        abortHit,
    output wire [7:0] rawByte
);
    reg  [7:0] window_q;
    reg  [7:0] valid_q;
    reg  [7:0] stuff_q;
    reg  [7:0] lastOut_q;
    reg  [2:0] ones_q;
    reg        flagPend_q;
    reg        abortPend_q;
    wire [7:0] winNext;
    wire       isStuff;
    wire       isFlag;
    wire       isAbort;

    assign winNext = {bitIn, window_q[7:1]};
    assign isFlag  = (winNext == `RDL_FLAG_PATTERN);
    assign isStuff = !bitIn && (ones_q == `RDL_STUFF_RUN);
    assign isAbort = bitIn && (ones_q == `RDL_ABORT_RUN);
    assign rawByte = lastOut_q;

    // ******************************************************
    // flag search, zero removal, abort detection
    // ******************************************************
    always @(posedge clk) begin
        if (rst || clear) begin
            window_q    <= 8'hff;
            ones_q      <= `RDL_IDLE_RUN;
            valid_q     <= 8'h00;
            stuff_q     <= 8'h00;
            lastOut_q   <= 8'hff;
            flagPend_q  <= 1'b0;
            abortPend_q <= 1'b0;
            dataValid   <= 1'b0;
            dataBit     <= 1'b0;
            flagHit     <= 1'b0;
            abortHit    <= 1'b0;
        end else begin
            dataValid <= 1'b0;
            flagHit   <= flagPend_q;
            abortHit  <= abortPend_q;
            flagPend_q  <= 1'b0;
            abortPend_q <= 1'b0;
            if (bitEn) begin
                window_q  <= winNext;
                lastOut_q <= {window_q[0], lastOut_q[7:1]};
                if (bitIn) begin
                    ones_q <= (ones_q == `RDL_IDLE_RUN) ? ones_q
                              : ones_q + 3'h1;
                end else begin
                    ones_q <= 3'h0;
                end
                // the oldest bit leaves ahead of any flag that follows it
                dataValid <= valid_q[0] && !stuff_q[0];
                dataBit   <= window_q[0];
                if (isFlag || isAbort) begin
                    valid_q <= 8'h00;
                    stuff_q <= 8'h00;
                end else begin
                    valid_q <= {1'b1, valid_q[7:1]};
                    stuff_q <= {isStuff, stuff_q[7:1]};
                end
                flagPend_q  <= isFlag;
                abortPend_q <= isAbort;
            end
        end
    end
endmodule

/* File: src/rdl_receiver.v */
`timescale 1ns/1ps
`include "rdl_consts.vh"

module rdl_receiver #(
    parameter AW = 2
) (
    input  wire       core_clk,
    input  wire       rst,
    input  wire [7:0] regAddr,
    input  wire [7:0] regWrData,
    input  wire       regWrStb,
    input  wire       regRdStb,
    output reg  [7:0] regRdData,
    input  wire       linkBitEn,
    input  wire       linkBit,
    output reg        rx_data_ready_out,
    output reg        rx_end_of_message_out
);
    localparam CW    = AW + 1;
    localparam DEPTH = 1 << AW;
    localparam EW    = `RDL_ENTRY_W;

    // ******************************************************
    // registers and state
    // ******************************************************
    reg  [1:0]    cfg_q;
    reg  [2:0]    thr_q;
    reg           enPrev_q;
    reg           awaitFirst_q;
    reg           inFrame_q;
    reg  [7:0]    shift_q;
    reg  [3:0]    bitCnt_q;
    reg  [7:0]    pending_q;
    reg           pendValid_q;
    reg           flush_q;
    reg  [AW-1:0] wrPtr_q;
    reg  [AW-1:0] rdPtr_q;
    reg  [CW-1:0] count_q;
    reg           overrun_q;
    reg           stFlg_q;
    reg           stEom_q;
    reg  [2:0]    stNvb_q;
    reg           stFe_q;

    reg           push;
    reg  [EW-1:0] pushWord;
    reg  [AW-1:0] rdPtr_d;
    reg  [CW-1:0] count_d;
    reg           overrun_d;
    reg           eomOut_d;

    wire          enable;
    wire          enRise;
    wire          fifoEmpty;
    wire          fifoFull;
    wire          dataRead;
    wire          statusRead;
    wire          pop;
    wire          accept;
    wire          dfValid;
    wire          dfBit;
    wire          dfFlag;
    wire          dfAbort;
    wire [7:0]    dfRaw;
    wire [EW-1:0] head;
    wire [7:0]    byteNext;
    wire [7:0]    partial;
    wire [7:0]    statusByte;
    wire [7:0]    cntWide;
    wire [2:0]    thrEff;

    assign enable     = cfg_q[`RDL_CFG_EN_BIT] | cfg_q[`RDL_CFG_ALT_BIT];
    assign enRise     = enable && !enPrev_q;
    assign fifoEmpty  = (count_q == {CW{1'b0}});
    assign fifoFull   = (count_q == DEPTH[CW-1:0]);
    assign dataRead   = regRdStb && (regAddr == `RDL_ADDR_DATA);
    assign statusRead = regRdStb && (regAddr == `RDL_ADDR_STATUS);
    assign pop        = dataRead && !fifoEmpty;
    assign accept     = push && (!fifoFull || pop);
    assign byteNext   = {dfBit, shift_q[7:1]};
    assign partial    = shift_q >> (4'h8 - bitCnt_q);
    assign cntWide    = {{(8-CW){1'b0}}, count_q};
    assign thrEff     = (thr_q == 3'h0) ? 3'h1 : thr_q;

    // status byte: what the last data read took out, plus live overrun
    assign statusByte = {1'b0, stNvb_q, stFlg_q, stEom_q, overrun_q,
                         stFe_q};

    // ******************************************************
    // link front end and fifo storage
    // ******************************************************
    rdl_deframer uDeframer (
        .clk       (core_clk),
        .rst       (rst),
        .clear     (enRise || !enable),
        .bitEn     (linkBitEn && enable),
        .bitIn     (linkBit),
        .dataValid (dfValid),
        .dataBit   (dfBit),
        .flagHit   (dfFlag),
        .abortHit  (dfAbort),
        .rawByte   (dfRaw)
    );

    // read address runs a step ahead so the head word is registered
    rdl_fifo_mem #(
        .W  (EW),
        .AW (AW)
    ) uFifoMem (
        .clk   (core_clk),
        .we    (accept),
        .waddr (wrPtr_q),
        .wdata (pushWord),
        .raddr (rdPtr_d),
        .rdata (head)
    );

    // ******************************************************
    // frame assembly: choose at most one fifo entry per cycle
    // ******************************************************
    // bit-oriented codes and idle are not interpreted here;
    // software recognises link states from the entries
    always @* begin
        push     = 1'b0;
        pushWord = {EW{1'b0}};
        if (enable) begin
            if (flush_q) begin
                // remainder of a frame closed by a flag or an abort
                push     = 1'b1;
                pushWord = {bitCnt_q[2:0], 1'b1, 1'b1, partial};
            end else if (dfFlag && awaitFirst_q) begin
                push     = 1'b1;
                pushWord = {3'h0, 1'b1, 1'b1, dfRaw};
            end else if (dfFlag && inFrame_q && pendValid_q) begin
                push     = 1'b1;
                pushWord = {3'h0, (bitCnt_q == 4'h0), 1'b1,
                            pending_q};
            end else if (dfAbort && inFrame_q && pendValid_q) begin
                // a held byte leaves first; a remainder follows it
                push     = 1'b1;
                pushWord = {3'h0, (bitCnt_q == 4'h0), 1'b1,
                            pending_q};
            end else if (dfAbort && inFrame_q && bitCnt_q != 4'h0) begin
                push     = 1'b1;
                pushWord = {bitCnt_q[2:0], 1'b1, 1'b1, partial};
            end else if (dfValid && inFrame_q && bitCnt_q == 4'h7
                         && pendValid_q) begin
                push     = 1'b1;
                pushWord = {3'h0, 1'b0, 1'b1, pending_q};
            end
        end
    end

    always @(posedge core_clk) begin
        if (rst) begin
            enPrev_q     <= 1'b0;
            awaitFirst_q <= 1'b0;
            inFrame_q    <= 1'b0;
            shift_q      <= 8'h00;
            bitCnt_q     <= 4'h0;
            pending_q    <= 8'h00;
            pendValid_q  <= 1'b0;
            flush_q      <= 1'b0;
        end else begin
            enPrev_q <= enable;
            flush_q  <= 1'b0;
            if (enRise || !enable) begin
                awaitFirst_q <= enRise;
                inFrame_q    <= 1'b0;
                bitCnt_q     <= 4'h0;
                pendValid_q  <= 1'b0;
            end else if (flush_q) begin
                bitCnt_q <= 4'h0;
            end else if (dfFlag) begin
                awaitFirst_q <= 1'b0;
                inFrame_q    <= 1'b1;
                pendValid_q  <= 1'b0;
                if (inFrame_q && bitCnt_q != 4'h0) begin
                    flush_q <= 1'b1;
                end else begin
                    bitCnt_q <= 4'h0;
                end
            end else if (dfAbort) begin
                inFrame_q   <= 1'b0;
                pendValid_q <= 1'b0;
                // bits after the held byte are kept, not dropped
                if (inFrame_q && pendValid_q && bitCnt_q != 4'h0) begin
                    flush_q <= 1'b1;
                end else begin
                    bitCnt_q <= 4'h0;
                end
            end else if (dfValid && inFrame_q) begin
                shift_q <= byteNext;
                if (bitCnt_q == 4'h7) begin
                    bitCnt_q    <= 4'h0;
                    pending_q   <= byteNext;
                    pendValid_q <= 1'b1;
                end else begin
                    bitCnt_q <= bitCnt_q + 4'h1;
                end
            end
        end
    end

    // ******************************************************
    // fifo pointers, fill level and overrun
    // ******************************************************
    always @* begin
        rdPtr_d   = pop ? rdPtr_q + {{(AW-1){1'b0}}, 1'b1} : rdPtr_q;
        count_d   = count_q;
        if (enRise) begin
            rdPtr_d = wrPtr_q;
            count_d = {CW{1'b0}};
        end else if (accept && !pop) begin
            count_d = count_q + {{(CW-1){1'b0}}, 1'b1};
        end else if (pop && !accept) begin
            count_d = count_q - {{(CW-1){1'b0}}, 1'b1};
        end
        // a new overrun beats a clear by the same status read
        overrun_d = (push && !accept) ? 1'b1
                  : (statusRead || enRise) ? 1'b0 : overrun_q;
        // end output: last byte of a frame read, or an overrun
        eomOut_d  = (pop && head[`RDL_E_EOM]) || (push && !accept) ? 1'b1
                  : (statusRead || enRise) ? 1'b0 : rx_end_of_message_out;
    end

    always @(posedge core_clk) begin
        if (rst) begin
            wrPtr_q   <= {AW{1'b0}};
            rdPtr_q   <= {AW{1'b0}};
            count_q   <= {CW{1'b0}};
            overrun_q <= 1'b0;
        end else begin
            if (accept && !enRise) begin
                wrPtr_q <= wrPtr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            rdPtr_q   <= rdPtr_d;
            count_q   <= count_d;
            overrun_q <= overrun_d;
        end
    end

    // ******************************************************
    // handshake outputs
    // ******************************************************
    always @(posedge core_clk) begin
        if (rst) begin
            rx_data_ready_out     <= 1'b0;
            rx_end_of_message_out <= 1'b0;
        end else begin
            // high while the fill level is at or above the threshold, taken as 1 when it is 0,
            // or while the overrun bit is set
            rx_data_ready_out     <= ({{(CW > 3 ? CW-3 : 0){1'b0}},
                                      thrEff} <= count_d)
                                     || overrun_d;
            rx_end_of_message_out <= eomOut_d;
        end
    end

    // ******************************************************
    // register port
    // ******************************************************
    always @(posedge core_clk) begin
        if (rst) begin
            cfg_q <= `RDL_CFG_RESET;
            thr_q <= `RDL_THR_RESET;
        end else if (regWrStb) begin
            if (regAddr == `RDL_ADDR_CONFIG) begin
                cfg_q <= {regWrData[`RDL_CFG_ALT_BIT],
                          regWrData[`RDL_CFG_EN_BIT]};
            end
            if (regAddr == `RDL_ADDR_INTCTL) begin
                thr_q <= regWrData[`RDL_THR_MSB:`RDL_THR_LSB];
            end
        end
    end

    // ******************************************************
    // status of the entry taken by the latest data read
    // ******************************************************
    always @(posedge core_clk) begin
        if (rst || enRise) begin
            stFlg_q <= 1'b0;
            stEom_q <= 1'b0;
            stNvb_q <= 3'h0;
            stFe_q  <= 1'b0;
        end else if (dataRead) begin
            if (pop) begin
                stFlg_q <= head[`RDL_E_FLG];
                stEom_q <= head[`RDL_E_EOM];
                stNvb_q <= head[`RDL_E_NVB_MSB:`RDL_E_NVB_LSB];
                // empty after this pop, counting an entry landing now
                stFe_q  <= (count_d == {CW{1'b0}});
            end else begin
                // empty fifo read leaves an all-zero status
                stFlg_q <= 1'b0;
                stEom_q <= 1'b0;
                stNvb_q <= 3'h0;
                stFe_q  <= 1'b0;
            end
        end
    end

    always @(posedge core_clk) begin
        if (rst) begin
            regRdData <= 8'h00;
        end else if (regRdStb) begin
            case (regAddr)
                `RDL_ADDR_CONFIG: regRdData <= {6'h00, cfg_q};
                `RDL_ADDR_INTCTL: regRdData <= {1'b0,
                    cntWide[`RDL_CNT_MSB-`RDL_CNT_LSB:0], 1'b0, thr_q};
                `RDL_ADDR_STATUS: regRdData <= statusByte;
                `RDL_ADDR_DATA:   regRdData <= pop ?
                                  head[`RDL_E_DATA_MSB:0] : 8'h00;
                default:          regRdData <= 8'h00;
            endcase
        end else begin
            regRdData <= 8'h00;
        end
    end
endmodule

/* File: verification/rdl_receiver_assertions.sv */
`timescale 1ns/1ps
`include "rdl_consts.vh"
module rdl_receiver_assertions #(
    parameter AW = 2
) (
    input wire       core_clk,
    input wire       rst,
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    input wire       regWrStb,
    input wire       regRdStb,
    input wire [7:0] regRdData,
    input wire       linkBitEn,
    input wire       linkBit,
    input wire       rx_data_ready_out,
    input wire       rx_end_of_message_out
);
    // ************************************************************
    // shared sequences
    // ************************************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    sequence s_data_read;
        regRdStb && regAddr == `RDL_ADDR_DATA;
    endsequence

    sequence s_status_read;
        regRdStb && regAddr == `RDL_ADDR_STATUS;
    endsequence

    // no recent link bit that could still land an entry or an overrun
    sequence s_link_quiet;
        !$past(linkBitEn) && !$past(linkBitEn, 2) && !$past(linkBitEn, 3);
    endsequence

    // ************************************************************
    // checks
    // ************************************************************
    a_rd_data_idle: assert property (
        !regRdStb |=> regRdData == 8'h00)
        else $error("read data not zero outside a read answer");
    a_unmapped_zero: assert property (
        regRdStb && (regAddr < `RDL_ADDR_CONFIG || regAddr > `RDL_ADDR_DATA)
        |=> regRdData == 8'h00)
        else $error("unmapped read returned nonzero data");
    a_reset_quiet: assert property (disable iff (1'b0)
        rst |=> !rx_data_ready_out && !rx_end_of_message_out)
        else $error("outputs not cleared by reset");
    a_ready_holds: assert property (
        rx_data_ready_out && !regRdStb && !regWrStb && !$past(regWrStb)
        |=> rx_data_ready_out)
        else $error("ready dropped without a register access");
    a_ready_rise_cause: assert property (
        $rose(rx_data_ready_out) |-> $past(linkBitEn, 2) ||
        $past(linkBitEn, 3) || $past(linkBitEn, 4) || $past(linkBitEn, 5) ||
        $past(regWrStb) || $past(regWrStb, 2))
        else $error("ready rose with no captured byte");
    a_eom_holds: assert property (
        rx_end_of_message_out && !regWrStb && !$past(regWrStb) &&
        !(regRdStb && regAddr == `RDL_ADDR_STATUS) |=> rx_end_of_message_out)
        else $error("end output dropped without a status read");
    a_eom_rise_cause: assert property (
        $rose(rx_end_of_message_out) |->
        $past(regRdStb && regAddr == `RDL_ADDR_DATA) || $past(linkBitEn) ||
        $past(linkBitEn, 2) || $past(linkBitEn, 3) || $past(linkBitEn, 4) ||
        $past(linkBitEn, 5))
        else $error("end output rose with no read or overrun");
    a_eom_clears: assert property (
        s_status_read ##0 s_link_quiet |=> !rx_end_of_message_out)
        else $error("status read left end output set");
    c_data_read: cover property (s_data_read ##1 rx_end_of_message_out);
endmodule

bind rdl_receiver rdl_receiver_assertions #(.AW(AW)) u_chk (
    .core_clk(core_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .linkBitEn(linkBitEn), .linkBit(linkBit),
    .rx_data_ready_out(rx_data_ready_out),
    .rx_end_of_message_out(rx_end_of_message_out)
);

/* File: verification/rdl_link_src.sv */
`timescale 1ns/1ps
module rdl_link_src (
    input  wire core_clk,
    output reg  linkBitEn,
    output reg  linkBit
);
    integer onesRun;

    initial begin
        linkBitEn = 1'b0;
        linkBit   = 1'b0;
        onesRun   = 0;
    end

    // one bit every four cycles; between strobes the line shows the inverse
    task send_bit(input logic b);
        begin
            @(posedge core_clk);
            linkBitEn <= 1'b1;
            linkBit   <= b;
            @(posedge core_clk);
            linkBitEn <= 1'b0;
            linkBit   <= ~b;
            repeat (2) @(posedge core_clk);
        end
    endtask

    // lsb first; when stuffed a zero follows every run of five ones
    task send_bits(input logic [7:0] v, input integer n, input bit stuffed);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1) begin
                send_bit(v[i]);
                onesRun = (v[i] && stuffed) ? onesRun + 1 : 0;
                if (onesRun == 5) begin
                    send_bit(1'b0);
                    onesRun = 0;
                end
            end
        end
    endtask

    task send_flag;
        send_bits(8'h7e, 8, 1'b0);
    endtask
endmodule

/* File: verification/rdl_receiver_tb_top.sv */
`timescale 1ns/1ps
`include "rdl_consts.vh"
module rdl_receiver_tb_top;
    logic       core_clk;
    logic       rst;
    logic [7:0] regAddr;
    logic [7:0] regWrData;
    logic       regWrStb;
    logic       regRdStb;
    wire  [7:0] regRdData;
    wire        linkBitEn;
    wire        linkBit;
    wire        rdy;
    wire        end_of_message_bit;
    integer     fail_count;
    integer     check_count;
    integer     i;
    logic [7:0] d;
    logic [7:0] s;

    rdl_receiver #(.AW(2)) u_dut (
        .core_clk(core_clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData(regRdData), .linkBitEn(linkBitEn), .linkBit(linkBit),
        .rx_data_ready_out(rdy), .rx_end_of_message_out(end_of_message_bit)
    );
    rdl_link_src u_src (
        .core_clk(core_clk), .linkBitEn(linkBitEn), .linkBit(linkBit)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task check(input string name, input logic [7:0] seen,
               input logic [7:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("CHECK FAILED %s expected %h seen %h",
                         name, exp, seen);
            end
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] v);
        begin
            @(posedge core_clk);
            regWrStb  <= 1'b1;
            regAddr   <= a;
            regWrData <= v;
            @(posedge core_clk);
            regWrStb  <= 1'b0;
        end
    endtask

    task rd(input logic [7:0] a, output logic [7:0] v);
        begin
            @(posedge core_clk);
            regRdStb <= 1'b1;
            regAddr  <= a;
            @(posedge core_clk);
            regRdStb <= 1'b0;
            #1;
            v = regRdData;
        end
    endtask

    // pop one entry; status compared without the flag-seen bit
    task pop(input logic [7:0] expD, input logic [7:0] expS);
        begin
            rd(`RDL_ADDR_DATA, d);
            check("data", d, expD);
            rd(`RDL_ADDR_STATUS, s);
            check("status", s & 8'h77, expS);
        end
    endtask

    task wait_ready;
        integer n;
        begin
            n = 0;
            while (rdy !== 1'b1 && n < 400) begin
                @(posedge core_clk);
                #1;
                n = n + 1;
            end
            check("ready", {7'h00, rdy}, 8'h01);
            repeat (8) @(posedge core_clk);
        end
    endtask

    // read pairs until the empty bit comes back
    task drain;
        integer n;
        begin
            n = 0;
            s = 8'h00;
            while (s[0] !== 1'b1 && n < 8) begin
                rd(`RDL_ADDR_DATA, d);
                rd(`RDL_ADDR_STATUS, s);
                n = n + 1;
            end
        end
    endtask

    task stop_test;
        begin
            $display("checks %0d mismatches %0d", check_count, fail_count);
            if (fail_count == 0 && check_count > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask

    initial begin
        #200000;
        fail_count = fail_count + 1;
        stop_test();
    end

    initial begin
        rst = 1'b1;
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrStb = 1'b0;
        regRdStb = 1'b0;
        fail_count = 0;
        check_count = 0;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        rd(`RDL_ADDR_CONFIG, d);
        check("config", d, 8'h00);
        rd(`RDL_ADDR_INTCTL, d);
        check("intctl", d, 8'h01);
        rd(8'h30, d);
        check("unmapped", d, 8'h00);
        wr(`RDL_ADDR_INTCTL, 8'h03);
        rd(`RDL_ADDR_INTCTL, d);
        check("threshold", d, 8'h03);
        wr(`RDL_ADDR_INTCTL, 8'h01);
        u_src.send_flag();
        pop(8'h00, 8'h00);
        check("idle ready", {7'h00, rdy}, 8'h00);
        $display("test reset_idle done");
        wr(`RDL_ADDR_CONFIG, 8'h01);
        u_src.send_flag();
        wait_ready();
        rd(`RDL_ADDR_DATA, d);
        check("first byte", d, 8'hff);
        check("eom out", {7'h00, end_of_message_bit}, 8'h01);
        rd(`RDL_ADDR_STATUS, s);
        check("first status", s & 8'h0f, 8'h0d);
        check("eom cleared", {7'h00, end_of_message_bit}, 8'h00);
        $display("test first_flag done");
        for (i = 1; i < 4; i = i + 1)
            u_src.send_bits(8'h11 * i[7:0], 8, 1'b1);
        u_src.send_flag();
        wait_ready();
        rd(`RDL_ADDR_INTCTL, d);
        check("fill level", d, 8'h31);
        pop(8'h11, 8'h00);
        check("ready held", {7'h00, rdy}, 8'h01);
        pop(8'h22, 8'h00);
        rd(`RDL_ADDR_DATA, d);
        check("last byte", d, 8'h33);
        check("eom last", {7'h00, end_of_message_bit}, 8'h01);
        rd(`RDL_ADDR_STATUS, s);
        check("last status", s & 8'h77, 8'h05);
        check("ready low", {7'h00, rdy}, 8'h00);
        $display("test whole_frame done");
        u_src.send_bits(8'h3e, 8, 1'b1);
        u_src.send_bits(8'h44, 8, 1'b1);
        u_src.send_bits(8'h05, 3, 1'b1);
        u_src.send_flag();
        wait_ready();
        pop(8'h3e, 8'h00);
        pop(8'h44, 8'h00);
        pop(8'h05, 8'h35);
        $display("test partial_frame done");
        wr(`RDL_ADDR_CONFIG, 8'h00);
        wr(`RDL_ADDR_CONFIG, 8'h02);
        u_src.send_flag();
        for (i = 1; i < 6; i = i + 1)
            u_src.send_bits(i[7:0], 8, 1'b1);
        u_src.send_flag();
        wait_ready();
        check("eom overrun", {7'h00, end_of_message_bit}, 8'h01);
        rd(`RDL_ADDR_DATA, d);
        check("alt first", d, 8'hff);
        rd(`RDL_ADDR_STATUS, s);
        check("overrun bit", {7'h00, s[1]}, 8'h01);
        check("eom after ovr", {7'h00, end_of_message_bit}, 8'h00);
        drain();
        pop(8'h00, 8'h00);
        $display("test overrun done");
        u_src.send_bits(8'h55, 8, 1'b1);
        u_src.send_bits(8'h66, 8, 1'b1);
        u_src.send_bits(8'h7f, 7, 1'b0);
        wait_ready();
        pop(8'h55, 8'h00);
        drain();
        check("abort partial", d, 8'h66);
        check("abort status", {6'h00, s[3:2]}, 8'h03);
        check("abort empty", {7'h00, s[0]}, 8'h01);
        $display("test abort done");
        stop_test();
    end
endmodule
